// [src/windowed_watchdog_pkg.sv]
/*
 * Constants, register map and helpers for the windowed watchdog.
 * Assumes an APB master on pclk and one-cycle tick pulses from the oscillators.
 */
// What this block does
// - when active, a count reaching the time-out without a clear resets the device
// - in windowed operation a clear is accepted only inside the open window
// - time-out programmable from 1 ms up to 256 s nominal
// - open window selectable from one eighth up to the whole period
// - count clocked by the 31 kHz oscillator or the 31.25 kHz divided medium oscillator
// - time base from the 3-bit config field or the control-register select field
// - 2-bit mode config field selects one of four modes
// - mode 11 runs always, ignores software enable, protects during sleep
// - mode 10 active while awake, disabled in sleep
// - mode 01 active when software enable is 1, disabled when 0
// - in software mode sleep does not change whether the watchdog is active
// - a clear outside the window is a violation and resets like a time-out
// - window from config field, or from control register when config is 111
// - in windowed operation an unarmed clear is a violation; reading control arms
// - a time-out during sleep wakes the device instead of resetting it
package windowed_watchdog_pkg;

	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned CNT_W    = 24;

	// register byte offsets
	localparam logic [7:0] OFS_CON0  = 8'h00;
	localparam logic [7:0] OFS_CON1  = 8'h04;
	localparam logic [7:0] OFS_STAT  = 8'h08;
	localparam logic [7:0] OFS_MASK  = 8'h0C;
	localparam logic [7:0] OFS_COUNT = 8'h10;

	// control register 0 fields
	localparam int unsigned CON0_SEN_BIT = 0;
	localparam int unsigned CON0_PS_LSB  = 1;
	localparam logic [4:0]  PS_RESET     = 5'h0B;   // 2 s nominal
	localparam logic [4:0]  PS_MAX       = 5'h12;   // 256 s nominal
	localparam int unsigned PS_BASE_LOG2 = 5;       // code 0 is 1:32, 1 ms

	// control register 1 fields
	localparam int unsigned CON1_WIN_LSB = 0;
	localparam int unsigned CON1_CS_LSB  = 4;
	localparam logic [2:0]  WIN_RESET    = 3'h7;
	localparam logic [2:0]  CS_RESET     = 3'h0;
	localparam logic [2:0]  CFG_USE_REG  = 3'h7;    // config value that defers to register
	localparam logic [2:0]  WIN_FULL     = 3'h7;    // 100 percent, no window

	// time base selections
	localparam logic [2:0]  TB_LF        = 3'h0;
	localparam logic [2:0]  TB_MF16      = 3'h1;
	localparam logic [3:0]  MF_DIV_LAST  = 4'hF;    // divide by sixteen

	// mode config encodings
	localparam logic [1:0]  MODE_OFF     = 2'h0;
	localparam logic [1:0]  MODE_SW      = 2'h1;
	localparam logic [1:0]  MODE_AWAKE   = 2'h2;
	localparam logic [1:0]  MODE_ON      = 2'h3;

	// status and mask bits
	localparam int unsigned EV_W         = 3;
	localparam int unsigned EV_TIMEOUT   = 0;
	localparam int unsigned EV_VIOLATION = 1;
	localparam int unsigned EV_WAKE      = 2;

	localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

	// period in ticks for a prescale code; reserved codes give the minimum
	function automatic logic [CNT_W-1:0] windowed_watchdog_period(input logic [4:0] ps);
		logic [4:0] eff;
		eff = (ps > PS_MAX) ? 5'h00 : ps;
		return CNT_W'(1) << (CNT_W'(eff) + CNT_W'(PS_BASE_LOG2));
	endfunction : windowed_watchdog_period

	// first count inside the open window, (w+1)/8 of the period at its end
	function automatic logic [CNT_W-1:0] windowed_watchdog_win_start(input logic [CNT_W-1:0] per,
			input logic [2:0] w);
		logic [CNT_W-1:0] eighth;
		eighth = per >> 3;
		return CNT_W'(eighth * CNT_W'(3'h7 - w));
	endfunction : windowed_watchdog_win_start

endpackage : windowed_watchdog_pkg

// [src/windowed_watchdog_cnt_if.sv]
/*
 * Interface between the watchdog control logic and its count register.
 * Assumes both ends run on the same clock and reset.
 */
`timescale 1ns/100ps
interface windowed_watchdog_cnt_if;
	logic                       tick;
	logic                       restart;
	logic [windowed_watchdog_pkg::CNT_W-1:0] count;

	modport ctl (output tick, output restart, input count);
	modport cnt (input tick, input restart, output count);
endinterface : windowed_watchdog_cnt_if

// [src/windowed_watchdog_counter.sv]
/*
 * Watchdog tick counter: restarts to zero, else advances one per tick.
 * Assumes tick arrives as single-cycle pulses on pclk; restart may stay high for many cycles and holds the count at zero.
 */
`timescale 1ns/100ps
module windowed_watchdog_counter (
	input  wire logic pclk,
	input  wire logic presetn,
	windowed_watchdog_cnt_if.cnt   cif
);
	logic [windowed_watchdog_pkg::CNT_W-1:0] count_q;
	logic [windowed_watchdog_pkg::CNT_W-1:0] count_d;

	// restart beats tick so a clear never leaves a stale count
	always_comb begin
		count_d = count_q;
		if (cif.restart) begin
			count_d = '0;
		end else if (cif.tick) begin
			count_d = count_q + windowed_watchdog_pkg::CNT_W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end

	assign cif.count = count_q;
endmodule : windowed_watchdog_counter

// [src/windowed_watchdog_top.sv]
/*
 * Windowed watchdog: APB registers, mode and time-base selection, window
 * check, reset and wake generation, sticky event flags with one interrupt.
 * Assumes synchronous inputs, oscillator ticks as one-cycle pulses and the
 * clear instruction as a one-cycle pulse from the core.
 */
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module windowed_watchdog_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [1:0]  watchdog_mode_config,
	input  wire logic [2:0]  time_base_config,
	input  wire logic [2:0]  window_size_config,
	input  wire logic        sleep_mode,
	input  wire logic        watchdog_clear_instruction,
	input  wire logic        low_freq_osc_tick,
	input  wire logic        medium_freq_osc_tick,
	output logic             wdt_reset,
	output logic             wdt_wake,
	output logic             irq
);
	windowed_watchdog_cnt_if cif ();

	windowed_watchdog_counter u_counter (
		.pclk    (pclk),
		.presetn (presetn),
		.cif     (cif)
	);

	// register state
	logic                          sen_q, sen_d;
	logic [4:0]                    ps_q, ps_d;
	logic [2:0]                    win_q, win_d;
	logic [2:0]                    cs_q, cs_d;
	logic [windowed_watchdog_pkg::EV_W-1:0]     stat_q, stat_d;
	logic [windowed_watchdog_pkg::EV_W-1:0]     mask_q, mask_d;
	logic                          armed_q, armed_d;
	logic                          sleep_q, sleep_d;
	logic [3:0]                    div_q, div_d;
	logic [31:0]                   prdata_d;
	logic                          pready_d, pslverr_d;
	logic                          wdt_reset_d, wdt_wake_d, irq_d;

	// decoded bus and watchdog terms
	logic                          setup_ph, acc_ph, mapped;
	logic                          wr_con0, wr_con1, wr_mask, rd_con0, rd_stat;
	logic                          active, windowed, tick, mf_tick, clr;
	logic                          timeout, accept, violation;
	logic [2:0]                    tb_sel, win_sel;
	logic [windowed_watchdog_pkg::CNT_W-1:0]    period, win_start;
	logic [windowed_watchdog_pkg::EV_W-1:0]     ev_set;

	// apb phases; the access edge is the one where pready is already high
	always_comb begin
		setup_ph = psel && !penable;
		acc_ph   = psel && penable && pready;
		mapped   = (paddr == windowed_watchdog_pkg::OFS_CON0) || (paddr == windowed_watchdog_pkg::OFS_CON1) ||
			(paddr == windowed_watchdog_pkg::OFS_STAT) || (paddr == windowed_watchdog_pkg::OFS_MASK) ||
			(paddr == windowed_watchdog_pkg::OFS_COUNT);
		wr_con0  = acc_ph && pwrite && (paddr == windowed_watchdog_pkg::OFS_CON0);
		wr_con1  = acc_ph && pwrite && (paddr == windowed_watchdog_pkg::OFS_CON1);
		wr_mask  = acc_ph && pwrite && (paddr == windowed_watchdog_pkg::OFS_MASK);
		rd_con0  = acc_ph && !pwrite && (paddr == windowed_watchdog_pkg::OFS_CON0);
		rd_stat  = acc_ph && !pwrite && (paddr == windowed_watchdog_pkg::OFS_STAT);
	end

	// mode table: which combinations keep the watchdog running
	always_comb begin
		case (watchdog_mode_config)
			windowed_watchdog_pkg::MODE_ON:    active = 1'b1;
			windowed_watchdog_pkg::MODE_AWAKE: active = !sleep_mode;
			windowed_watchdog_pkg::MODE_SW:    active = sen_q;
			windowed_watchdog_pkg::MODE_OFF:   active = 1'b0;
			default:              active = 1'b0;
		endcase
	end

	// time base and window source; config 111 hands control to the register
	always_comb begin
		tb_sel  = (time_base_config == windowed_watchdog_pkg::CFG_USE_REG) ? cs_q : time_base_config;
		win_sel = (window_size_config == windowed_watchdog_pkg::CFG_USE_REG) ? win_q
			: window_size_config;
		mf_tick = medium_freq_osc_tick && (div_q == windowed_watchdog_pkg::MF_DIV_LAST);
		// reserved selections fall back to the low oscillator
		tick    = (tb_sel == windowed_watchdog_pkg::TB_MF16) ? mf_tick : low_freq_osc_tick;
		div_d   = medium_freq_osc_tick ? div_q + 4'h1 : div_q;
	end

	// period, window and the three watchdog outcomes
	always_comb begin
		period    = windowed_watchdog_pkg::windowed_watchdog_period(ps_q);
		win_start = windowed_watchdog_pkg::windowed_watchdog_win_start(period, win_sel);
		windowed  = (win_sel != windowed_watchdog_pkg::WIN_FULL);
		clr       = watchdog_clear_instruction && active;
		timeout   = active && tick && (cif.count == period - windowed_watchdog_pkg::CNT_W'(1));
		// in windowed operation an unarmed or early clear counts as a violation
		accept    = clr && (!windowed || (armed_q && cif.count >= win_start));
		violation = clr && !accept;
		sleep_d   = sleep_mode;
	end

	// count restart: every clearing condition, including sleep entry and exit
	always_comb begin
		cif.tick    = tick;
		cif.restart = !active || accept || timeout || violation || wr_con0 || wr_con1 ||
			(sleep_mode != sleep_q);
	end

	// control registers; arming comes from a read of control register 0
	always_comb begin
		sen_d   = sen_q;
		ps_d    = ps_q;
		win_d   = win_q;
		cs_d    = cs_q;
		mask_d  = mask_q;
		armed_d = armed_q;
		if (wr_con0) begin
			sen_d = pwdata[windowed_watchdog_pkg::CON0_SEN_BIT];
			ps_d  = pwdata[windowed_watchdog_pkg::CON0_PS_LSB +: 5];
		end
		if (wr_con1) begin
			win_d = pwdata[windowed_watchdog_pkg::CON1_WIN_LSB +: 3];
			cs_d  = pwdata[windowed_watchdog_pkg::CON1_CS_LSB +: 3];
		end
		if (wr_mask) begin
			mask_d = pwdata[windowed_watchdog_pkg::EV_W-1:0];
		end
		// arming is spent by any clear, good or bad
		if (clr) begin
			armed_d = 1'b0;
		end else if (rd_con0) begin
			armed_d = 1'b1;
		end
	end

	// sticky events: a read clears only what it reported, so an event landing
	// between setup and access is kept; a new event in the clear cycle survives
	always_comb begin
		ev_set                         = '0;
		ev_set[windowed_watchdog_pkg::EV_TIMEOUT]   = timeout && !sleep_mode;
		ev_set[windowed_watchdog_pkg::EV_VIOLATION] = violation;
		ev_set[windowed_watchdog_pkg::EV_WAKE]      = timeout && sleep_mode;
		stat_d = (stat_q & ~(rd_stat ? prdata[windowed_watchdog_pkg::EV_W-1:0] : '0)) | ev_set;
		irq_d  = |(stat_d & mask_d);
		// a time-out in sleep wakes rather than resets
		wdt_reset_d = (timeout && !sleep_mode) || violation;
		wdt_wake_d  = timeout && sleep_mode;
	end

	// apb answer: no wait states, data and error prepared during setup
	always_comb begin
		prdata_d  = windowed_watchdog_pkg::RD_ZERO;
		pready_d  = setup_ph;
		pslverr_d = setup_ph && !mapped;
		if (setup_ph && !pwrite) begin
			case (paddr)
				windowed_watchdog_pkg::OFS_CON0: begin
					prdata_d[windowed_watchdog_pkg::CON0_SEN_BIT]     = sen_q;
					prdata_d[windowed_watchdog_pkg::CON0_PS_LSB +: 5] = ps_q;
				end
				windowed_watchdog_pkg::OFS_CON1: begin
					prdata_d[windowed_watchdog_pkg::CON1_WIN_LSB +: 3] = win_q;
					prdata_d[windowed_watchdog_pkg::CON1_CS_LSB +: 3]  = cs_q;
				end
				windowed_watchdog_pkg::OFS_STAT:  prdata_d[windowed_watchdog_pkg::EV_W-1:0] = stat_q;
				windowed_watchdog_pkg::OFS_MASK:  prdata_d[windowed_watchdog_pkg::EV_W-1:0] = mask_q;
				windowed_watchdog_pkg::OFS_COUNT: prdata_d[windowed_watchdog_pkg::CNT_W-1:0] = cif.count;
				default:             prdata_d = windowed_watchdog_pkg::RD_ZERO;
			endcase
		end
	end

	// all state but the count, and all outputs, registered here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sen_q     <= 1'b0;
			ps_q      <= windowed_watchdog_pkg::PS_RESET;
			win_q     <= windowed_watchdog_pkg::WIN_RESET;
			cs_q      <= windowed_watchdog_pkg::CS_RESET;
			stat_q    <= '0;
			mask_q    <= '0;
			armed_q   <= 1'b0;
			sleep_q   <= 1'b0;
			div_q     <= 4'h0;
			prdata    <= windowed_watchdog_pkg::RD_ZERO;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			wdt_reset <= 1'b0;
			wdt_wake  <= 1'b0;
			irq       <= 1'b0;
		end else begin
			sen_q     <= sen_d;
			ps_q      <= ps_d;
			win_q     <= win_d;
			cs_q      <= cs_d;
			stat_q    <= stat_d;
			mask_q    <= mask_d;
			armed_q   <= armed_d;
			sleep_q   <= sleep_d;
			div_q     <= div_d;
			prdata    <= prdata_d;
			pready    <= pready_d;
			pslverr   <= pslverr_d;
			wdt_reset <= wdt_reset_d;
			wdt_wake  <= wdt_wake_d;
			irq       <= irq_d;
		end
	end

	// checks on mode, window and outcome timing
	property p_mode_on;
		@(posedge pclk) disable iff (!presetn)
		watchdog_mode_config == windowed_watchdog_pkg::MODE_ON && tick &&
			cif.count == period - windowed_watchdog_pkg::CNT_W'(1) |=> wdt_reset || wdt_wake;
	endproperty
	a_mode_on: assert property (p_mode_on) else $error("mode 11 not timing out");

	property p_mode_awake;
		@(posedge pclk) disable iff (!presetn)
		watchdog_mode_config == windowed_watchdog_pkg::MODE_AWAKE && sleep_mode
			|=> cif.count == '0 && !wdt_reset && !wdt_wake;
	endproperty
	a_mode_awake: assert property (p_mode_awake) else $error("mode 10 wrong");

	property p_mode_sw;
		@(posedge pclk) disable iff (!presetn)
		watchdog_mode_config == windowed_watchdog_pkg::MODE_SW && !sen_q
			|=> cif.count == '0 && !wdt_reset && !wdt_wake;
	endproperty
	a_mode_sw: assert property (p_mode_sw) else $error("mode 01 wrong");

	property p_mode_off;
		@(posedge pclk) disable iff (!presetn)
		watchdog_mode_config == windowed_watchdog_pkg::MODE_OFF |=> cif.count == '0 && !wdt_reset;
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("mode 00 counting");

	property p_timeout_reset;
		@(posedge pclk) disable iff (!presetn)
		active && tick && !sleep_mode && cif.count == period - windowed_watchdog_pkg::CNT_W'(1)
			|=> wdt_reset && !wdt_wake ##1 !wdt_reset;
	endproperty
	a_timeout_reset: assert property (p_timeout_reset) else $error("no reset on time-out");

	property p_sleep_wake;
		@(posedge pclk) disable iff (!presetn)
		timeout && sleep_mode |=> wdt_wake && !wdt_reset;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("sleep time-out reset");

	property p_unarmed;
		@(posedge pclk) disable iff (!presetn)
		watchdog_clear_instruction && active && windowed && !armed_q |=> wdt_reset;
	endproperty
	a_unarmed: assert property (p_unarmed) else $error("unarmed clear accepted");

	property p_early;
		@(posedge pclk) disable iff (!presetn)
		watchdog_clear_instruction && active && cif.count < win_start |=> wdt_reset;
	endproperty
	a_early: assert property (p_early) else $error("early clear accepted");

	property p_accept;
		@(posedge pclk) disable iff (!presetn)
		accept |=> cif.count == '0 && !wdt_reset;
	endproperty
	a_accept: assert property (p_accept) else $error("accepted clear not restarting");

	property p_reset_cause;
		@(posedge pclk) disable iff (!presetn)
		$rose(wdt_reset) |-> $past(timeout) || $past(violation);
	endproperty
	a_reset_cause: assert property (p_reset_cause) else $error("reset without cause");

	property p_min_period;
		@(posedge pclk) disable iff (!presetn)
		ps_q > windowed_watchdog_pkg::PS_MAX |-> period == windowed_watchdog_pkg::CNT_W'(32);
	endproperty
	a_min_period: assert property (p_min_period) else $error("reserved period wrong");

	c_accept: cover property (@(posedge pclk) disable iff (!presetn) accept && windowed);
	c_violation: cover property (@(posedge pclk) disable iff (!presetn) violation);
	c_wake: cover property (@(posedge pclk) disable iff (!presetn) timeout && sleep_mode);
	c_timeout: cover property (@(posedge pclk) disable iff (!presetn) timeout && !sleep_mode);

endmodule : windowed_watchdog_top

// [verification/windowed_watchdog_top_test.sv]
/*
 * Self-checking bench for the windowed watchdog: registers, modes, time bases, window.
 * Assumes the zero-wait APB slave and one-cycle tick and clear pulses of the top.
 */
`timescale 1ns/100ps
module windowed_watchdog_top_test;
	logic        pclk, presetn, psel, penable, pwrite, sleep_mode, clr, lf, mf;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, err, wdt_reset, wdt_wake, irq;
	logic [1:0]  mode;
	logic [2:0]  tbc, wcfg;
	int          err_count, total_checks, n_rst, n_wake, cyc, seed, w, n, e, per;
	int          ps_tab [3] = '{0, 1, 'h13};

	windowed_watchdog_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .watchdog_mode_config(mode),
		.time_base_config(tbc), .window_size_config(wcfg), .sleep_mode(sleep_mode),
		.watchdog_clear_instruction(clr), .low_freq_osc_tick(lf),
		.medium_freq_osc_tick(mf), .wdt_reset(wdt_reset), .wdt_wake(wdt_wake), .irq(irq));

	// free-running 125 MHz clock
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// pulse counters and hang guard, sized well above the expected few thousand cycles
	always @(posedge pclk) begin
		cyc++;
		if (wdt_reset === 1'b1) n_rst++;
		if (wdt_wake === 1'b1) n_wake++;
		if (cyc == 30000) begin
			err_count++;
			tally_and_finish();
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// one transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k == 20) begin
			err_count++;
			$display("[ERR] pready expected 1 seen %b", pready);
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, exp, rd);
	endtask : rdchk

	// restart the count, drop old status, zero the pulse counters
	task automatic restart(input logic [31:0] con0);
		apb(1'b1, windowed_watchdog_pkg::OFS_CON0, con0);
		apb(1'b0, windowed_watchdog_pkg::OFS_STAT, 32'h0000_0000);
		n_rst = 0;
		n_wake = 0;
	endtask : restart

	// oscillator ticks with a random idle gap between them
	task automatic tick(input int cnt, input logic med);
		repeat (cnt) begin
			@(posedge pclk);
			if (med) mf <= 1'b1;
			else lf <= 1'b1;
			@(posedge pclk);
			lf <= 1'b0;
			mf <= 1'b0;
			repeat ($random(seed) & 1) @(posedge pclk);
		end
		repeat (3) @(posedge pclk);
	endtask : tick

	// window case: nt ticks, optional arming read, then one clear
	task automatic win(input int wv, input int nt, input logic arm);
		restart(32'h0000_0000);
		tick(nt, 1'b0);
		if (arm) apb(1'b0, windowed_watchdog_pkg::OFS_CON0, 32'h0000_0000);
		@(posedge pclk);
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		repeat (3) @(posedge pclk);
		e = (wv != 7) && (!arm || nt < 4 * (7 - wv));
		chk("violation reset", 32'(e), 32'(n_rst));
		rdchk("violation status", windowed_watchdog_pkg::OFS_STAT, e ? 32'h0000_0002 : 32'h0000_0000);
		if (!e) rdchk("count after clear", windowed_watchdog_pkg::OFS_COUNT, 32'h0000_0000);
	endtask : win

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish

	initial begin
		{psel, penable, pwrite, sleep_mode, clr, lf, mf} = '0;
		{paddr, pwdata} = '0;
		{err_count, total_checks, n_rst, n_wake, cyc} = '0;
		seed = 56387;
		mode = 2'h3;
		tbc = 3'h0;
		wcfg = 3'h7;
		presetn = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		// reset values and an unmapped place
		rdchk("con0 reset", windowed_watchdog_pkg::OFS_CON0, 32'h0000_0016);
		chk("slverr mapped", 32'h0000_0000, 32'(err));
		rdchk("con1 reset", windowed_watchdog_pkg::OFS_CON1, 32'h0000_0007);
		rdchk("mask reset", windowed_watchdog_pkg::OFS_MASK, 32'h0000_0000);
		rdchk("unmapped read", 8'h14, 32'h0000_0000);
		chk("slverr unmapped", 32'h0000_0001, 32'(err));
		// time-out length per prescale code, reserved code gives the minimum
		foreach (ps_tab[i]) begin
			per = 32 << ((ps_tab[i] > 'h12) ? 0 : ps_tab[i]);
			restart(32'(ps_tab[i] << 1));
			tick(per - 1, 1'b0);
			chk("early reset", 32'h0000_0000, 32'(n_rst));
			tick(1, 1'b0);
			chk("timeout reset", 32'h0000_0001, 32'(n_rst));
		end
		// every mode, software enable and power state combination
		apb(1'b1, windowed_watchdog_pkg::OFS_MASK, 32'h0000_0007);
		for (int m = 0; m < 4; m++)
			for (int s = 0; s < 2; s++)
				for (int sl = 0; sl < 2; sl++) begin
					mode <= 2'(m);
					sleep_mode <= 1'(sl);
					restart(32'(s));
					e = (m == 3) || (m == 2 && sl == 0) || (m == 1 && s == 1);
					tick(32, 1'b0);
					chk("mode reset", 32'(e && !sl), 32'(n_rst));
					chk("mode wake", 32'(e && sl), 32'(n_wake));
					chk("irq set", 32'(e), 32'(irq));
					rdchk("mode status", windowed_watchdog_pkg::OFS_STAT, e ? (sl ? 4 : 1) : 0);
					repeat (2) @(posedge pclk);
					chk("irq cleared", 32'h0000_0000, 32'(irq));
				end
		mode <= 2'h3;
		sleep_mode <= 1'b0;
		// divided medium time base from the config field, event masked
		tbc <= 3'h1;
		apb(1'b1, windowed_watchdog_pkg::OFS_MASK, 32'h0000_0000);
		restart(32'h0000_0000);
		tick(40, 1'b0);
		chk("low ticks ignored", 32'h0000_0000, 32'(n_rst));
		apb(1'b1, windowed_watchdog_pkg::OFS_CON0, 32'h0000_0000);
		tick(512, 1'b1);
		chk("medium timeout", 32'h0000_0001, 32'(n_rst));
		chk("irq masked", 32'h0000_0000, 32'(irq));
		rdchk("masked status", windowed_watchdog_pkg::OFS_STAT, 32'h0000_0001);
		// time base from the control register select field
		tbc <= 3'h7;
		apb(1'b1, windowed_watchdog_pkg::OFS_CON1, 32'h0000_0017);
		restart(32'h0000_0000);
		tick(512, 1'b1);
		chk("select timeout", 32'h0000_0001, 32'(n_rst));
		apb(1'b1, windowed_watchdog_pkg::OFS_CON1, 32'h0000_0007);
		tbc <= 3'h0;
		// window edges, restart after a clear, unarmed clear, full window
		wcfg <= 3'h3;
		win(3, 16, 1'b1);
		tick(31, 1'b0);
		chk("restarted count", 32'h0000_0000, 32'(n_rst));
		tick(1, 1'b0);
		chk("restarted timeout", 32'h0000_0001, 32'(n_rst));
		win(3, 15, 1'b1);
		win(3, 20, 1'b0);
		wcfg <= 3'h7;
		win(7, 0, 1'b0);
		apb(1'b1, windowed_watchdog_pkg::OFS_CON1, 32'h0000_0003);
		win(3, 15, 1'b1);
		apb(1'b1, windowed_watchdog_pkg::OFS_CON1, 32'h0000_0007);
		// random window sizes and clear moments
		repeat (8) begin
			w = {$random(seed)} % 7;
			n = {$random(seed)} % 32;
			wcfg <= 3'(w);
			win(w, n, 1'b1);
		end
		tally_and_finish();
	end
endmodule : windowed_watchdog_top_test
